// ### core/cawd_pkg.sv
/*
 * Constants for the counter array block: register addresses, bit positions,
 * values after reset and timebase divider counts.
 * Assumes a byte-wide special function register bus on the system clock.
 */
package cawd_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CTL      = 8'hd8;
    localparam logic [7:0] ADDR_MODE     = 8'hd9;
    localparam logic [7:0] ADDR_CNT_LO   = 8'he9;
    localparam logic [7:0] ADDR_CNT_HI   = 8'hf9;
    localparam logic [7:0] ADDR_CPM_BASE = 8'hc0;
    localparam logic [7:0] ADDR_CPL_BASE = 8'he0;
    localparam logic [7:0] ADDR_CPH_BASE = 8'hf0;
    // control register bits
    localparam int CTL_OVF = 7;
    localparam int CTL_RUN = 6;
    // array mode register bits
    localparam int MD_IDLE = 7;
    localparam int MD_WATCHDOG_ENABLE_BIT = 6;
    localparam int MD_LOCK = 5;
    localparam int MD_TBH  = 3;
    localparam int MD_TBL  = 1;
    localparam logic [7:0] MD_RW_MASK = 8'hef;
    // module mode register bits
    localparam int CPM_WIDE = 7;
    localparam int CPM_ECOM = 6;
    localparam int CPM_MAT  = 3;
    localparam int CPM_PWM  = 1;
    // forced mode of the watchdog module: compare and match only
    localparam logic [7:0] CPM_SWTIMER = 8'h48;
    // values after reset
    localparam logic [7:0]  CTL_RESET  = 8'h00;
    localparam logic [7:0]  MODE_RESET = 8'h40;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [7:0]  CMP_RESET  = 8'h00;
    // timebase selections
    localparam logic [2:0] TB_DIV12 = 3'b000;
    localparam logic [2:0] TB_DIV4  = 3'b001;
    localparam logic [2:0] TB_T0OVF = 3'b010;
    localparam logic [2:0] TB_ECI   = 3'b011;
    localparam logic [2:0] TB_SYS   = 3'b100;
    localparam logic [2:0] TB_EXT8  = 3'b101;
    // divider terminal counts
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] DIV8_LAST  = 3'h7;
    // index of the module that serves as watchdog
    localparam int WD_MOD = 5;
endpackage : cawd_pkg

// ### core/cawd_core.sv
/*
 * Counter array with 16-bit pwm modules and the module-5 watchdog.
 * Assumes the processor core reaches the registers over a byte-wide
 * special function register port on ref_clk_i, with bit writes for the
 * control register; the watchdog pulse goes to the system reset controller.
 */
module cawd_core #(
    parameter int NUM_MOD = 6
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_b_i,
    // special function register port
    input  wire logic [7:0]         sfr_addr_i,
    input  wire logic [7:0]         sfr_wdata_i,
    input  wire logic               sfr_wr_i,
    input  wire logic               sfr_rd_i,
    input  wire logic               sfr_bit_wr_i,
    input  wire logic [2:0]         sfr_bit_idx_i,
    input  wire logic               sfr_bit_val_i,
    output logic      [7:0]         sfr_rdata_o,
    // timebase sources and processor state
    input  wire logic               timer0_ovf_i,
    input  wire logic               ext_count_i,
    input  wire logic               ext_clk_i,
    input  wire logic               cpu_idle_i,
    // module pins and watchdog reset
    output logic      [NUM_MOD-1:0] module_output_pin_o,
    output logic                    wdt_reset_o
);
    typedef struct packed {
        logic [7:0]              ctl;
        logic [7:0]              md;
        logic [15:0]             cnt;
        logic [NUM_MOD-1:0][7:0] cpm;
        logic [NUM_MOD-1:0][7:0] cpl;
        logic [NUM_MOD-1:0][7:0] cph;
        logic [NUM_MOD-1:0]      pout;
        logic                    wdt_rst;
        logic [7:0]              rdata;
        logic [3:0]              div12;
        logic [1:0]              div4;
        logic [2:0]              div8;
        logic [2:0]              eci_sy;
        logic [2:0]              ext_sy;
    } cawd_state_t;

    // the watchdog module must exist; the address windows hold eight
    if (NUM_MOD != 6) begin : g_check
        $error("cawd_core: NUM_MOD must be 6");
    end

    // reset release through two flip-flops
    logic [1:0] rst_sync;
    logic       rst_sync_b;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync[1];

    // whether an address falls inside a window of eight at an index below NUM_MOD
    function automatic logic win_hit(input logic [7:0] a,
                                     input logic [7:0] base);
        win_hit = (a[7:3] == base[7:3]) && (a[2:0] < 3'(NUM_MOD));
    endfunction

    cawd_state_t st;
    cawd_state_t next_st;
    logic        wdt_en;
    logic        tick;
    logic        src;
    logic        ctl_wr;
    logic [7:0]  ctl_wval;
    logic        force_rst;
    logic        wd_timeout;
    logic [15:0] cnt_inc;
    logic [2:0]  widx;

    // lock keeps the watchdog on even with the enable bit cleared
    assign wdt_en = st.md[cawd_pkg::MD_WATCHDOG_ENABLE_BIT] | st.md[cawd_pkg::MD_LOCK];
    assign cnt_inc = st.cnt + 16'h0001;
    assign widx = sfr_addr_i[2:0];

    // timebase pulse; reserved codes never count
    always_comb begin
        case (st.md[cawd_pkg::MD_TBH:cawd_pkg::MD_TBL])
            cawd_pkg::TB_DIV12: src = (st.div12 == cawd_pkg::DIV12_LAST);
            cawd_pkg::TB_DIV4:  src = (st.div4 == cawd_pkg::DIV4_LAST);
            cawd_pkg::TB_T0OVF: src = timer0_ovf_i;
            cawd_pkg::TB_ECI:   src = !st.eci_sy[1] && st.eci_sy[2];
            cawd_pkg::TB_SYS:   src = 1'b1;
            cawd_pkg::TB_EXT8:  src = st.ext_sy[1] && !st.ext_sy[2]
                                      && (st.div8 == cawd_pkg::DIV8_LAST);
            default:            src = 1'b0;
        endcase
    end

    // watchdog forces the counter on; idle suspend still halts it
    assign tick = (st.ctl[cawd_pkg::CTL_RUN] | wdt_en)
                  && !(st.md[cawd_pkg::MD_IDLE] && cpu_idle_i)
                  && src;

    // control register byte or bit write
    always_comb begin
        ctl_wr = 1'b0;
        ctl_wval = st.ctl;
        if (sfr_wr_i && sfr_addr_i == cawd_pkg::ADDR_CTL) begin
            ctl_wr = 1'b1;
            ctl_wval = sfr_wdata_i;
        end else if (sfr_bit_wr_i) begin
            ctl_wr = 1'b1;
            ctl_wval[sfr_bit_idx_i] = sfr_bit_val_i;
        end
    end

    assign force_rst = ctl_wr && ctl_wval[cawd_pkg::WD_MOD] && wdt_en;
    // update byte meeting counter high as the low byte wraps
    assign wd_timeout = wdt_en && tick && (st.cnt[7:0] == 8'hff)
                        && (st.cph[cawd_pkg::WD_MOD] == st.cnt[15:8]);

    // next state of the whole block
    always_comb begin
        logic [7:0]  m;
        logic [15:0] cmp;
        logic        hit;
        m = 8'h00;
        cmp = 16'h0000;
        hit = 1'b0;
        next_st = st;
        next_st.eci_sy = {st.eci_sy[1:0], ext_count_i};
        next_st.ext_sy = {st.ext_sy[1:0], ext_clk_i};
        // free-running prescalers keep the divide ratios exact
        next_st.div12 = (st.div12 == cawd_pkg::DIV12_LAST) ? 4'h0
                        : st.div12 + 4'h1;
        next_st.div4 = st.div4 + 2'h1;
        if (st.ext_sy[1] && !st.ext_sy[2]) begin
            next_st.div8 = st.div8 + 3'h1;
        end
        // control flags: hardware set wins over a clear in the same cycle
        next_st.ctl = ctl_wval;
        if (tick && st.cnt == 16'hffff) begin
            next_st.ctl[cawd_pkg::CTL_OVF] = 1'b1;
        end
        // counter, writes locked out while the watchdog runs
        if (tick) begin
            next_st.cnt = cnt_inc;
        end
        if (sfr_wr_i && !wdt_en) begin
            if (sfr_addr_i == cawd_pkg::ADDR_CNT_LO) begin
                next_st.cnt[7:0] = sfr_wdata_i;
            end
            if (sfr_addr_i == cawd_pkg::ADDR_CNT_HI) begin
                next_st.cnt[15:8] = sfr_wdata_i;
            end
        end
        // mode register: only the enable bit moves while enabled
        if (sfr_wr_i && sfr_addr_i == cawd_pkg::ADDR_MODE) begin
            if (wdt_en) begin
                next_st.md[cawd_pkg::MD_WATCHDOG_ENABLE_BIT] = sfr_wdata_i[cawd_pkg::MD_WATCHDOG_ENABLE_BIT];
            end else begin
                next_st.md = sfr_wdata_i & cawd_pkg::MD_RW_MASK;
            end
            // lock survives any write until the next reset
            next_st.md[cawd_pkg::MD_LOCK] = next_st.md[cawd_pkg::MD_LOCK]
                                            | st.md[cawd_pkg::MD_LOCK];
        end
        // compare modules
        for (int i = 0; i < NUM_MOD; i++) begin
            m = (i == cawd_pkg::WD_MOD && wdt_en) ? cawd_pkg::CPM_SWTIMER
                : st.cpm[i];
            cmp = {st.cph[i], st.cpl[i]};
            hit = tick && (cnt_inc == cmp);
            if (hit && m[cawd_pkg::CPM_ECOM] && m[cawd_pkg::CPM_MAT]) begin
                next_st.ctl[i] = 1'b1;
            end
            // compare value zero re-matches at wrap, so stays high
            if (!(m[cawd_pkg::CPM_ECOM] && m[cawd_pkg::CPM_PWM]
                  && m[cawd_pkg::CPM_WIDE])) begin
                next_st.pout[i] = 1'b0;
            end else if (hit) begin
                next_st.pout[i] = 1'b1;
            end else if (tick && st.cnt == 16'hffff) begin
                next_st.pout[i] = 1'b0;
            end
        end
        // compare byte and module mode writes
        if (sfr_wr_i && widx < 3'(NUM_MOD)) begin
            if (win_hit(sfr_addr_i, cawd_pkg::ADDR_CPL_BASE)) begin
                next_st.cpl[widx] = sfr_wdata_i;
                next_st.cpm[widx][cawd_pkg::CPM_ECOM] = 1'b0;
            end
            if (win_hit(sfr_addr_i, cawd_pkg::ADDR_CPH_BASE)) begin
                if (widx == 3'(cawd_pkg::WD_MOD) && wdt_en) begin
                    next_st.cph[widx] = st.cnt[15:8]
                        + st.cpl[cawd_pkg::WD_MOD];
                end else begin
                    next_st.cph[widx] = sfr_wdata_i;
                    next_st.cpm[widx][cawd_pkg::CPM_ECOM] = 1'b1;
                end
            end
            if (win_hit(sfr_addr_i, cawd_pkg::ADDR_CPM_BASE)
                && !(widx == 3'(cawd_pkg::WD_MOD) && wdt_en)) begin
                next_st.cpm[widx] = sfr_wdata_i;
            end
        end
        // single registered reset request
        next_st.wdt_rst = wd_timeout || force_rst;
        // read data, unmapped addresses read zero
        if (sfr_rd_i) begin
            next_st.rdata = 8'h00;
            case (sfr_addr_i)
                cawd_pkg::ADDR_CTL:    next_st.rdata = st.ctl;
                cawd_pkg::ADDR_MODE:   next_st.rdata = st.md;
                cawd_pkg::ADDR_CNT_LO: next_st.rdata = st.cnt[7:0];
                cawd_pkg::ADDR_CNT_HI: next_st.rdata = st.cnt[15:8];
                default: begin
                    if (win_hit(sfr_addr_i, cawd_pkg::ADDR_CPL_BASE)) begin
                        next_st.rdata = st.cpl[widx];
                    end else if (win_hit(sfr_addr_i,
                                         cawd_pkg::ADDR_CPH_BASE)) begin
                        next_st.rdata = st.cph[widx];
                    end else if (win_hit(sfr_addr_i,
                                         cawd_pkg::ADDR_CPM_BASE)) begin
                        next_st.rdata = st.cpm[widx];
                    end
                end
            endcase
        end
    end

    // state register; watchdog enabled out of reset
    always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0;
            st.ctl <= cawd_pkg::CTL_RESET;
            st.md <= cawd_pkg::MODE_RESET;
            st.cnt <= cawd_pkg::CNT_RESET;
            st.cpl <= {NUM_MOD{cawd_pkg::CMP_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata_o = st.rdata;
    assign module_output_pin_o = st.pout;
    assign wdt_reset_o = st.wdt_rst;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_sync_b);

    sequence s_update;
        wdt_en && sfr_wr_i
        && sfr_addr_i == (cawd_pkg::ADDR_CPH_BASE | 8'(cawd_pkg::WD_MOD));
    endsequence

    update_load_a: assert property (s_update |=>
        st.cph[cawd_pkg::WD_MOD] == $past(st.cnt[15:8])
        + $past(st.cpl[cawd_pkg::WD_MOD]))
        else $error("update byte not loaded with counter plus offset");
    wdt_timeout_a: assert property (wd_timeout |=> wdt_reset_o)
        else $error("watchdog timeout gave no reset pulse");
    force_reset_a: assert property (ctl_wr && ctl_wval[5] && wdt_en
        |=> wdt_reset_o)
        else $error("forced watchdog reset missing");
    lock_sticky_a: assert property (st.md[cawd_pkg::MD_LOCK]
        |=> st.md[cawd_pkg::MD_LOCK] && wdt_en)
        else $error("lock bit lost before reset");
    pwm_off_a: assert property (!st.cpm[0][cawd_pkg::CPM_ECOM]
        |=> !module_output_pin_o[0])
        else $error("output high with compare disabled");
    ovf_flag_a: assert property (tick && st.cnt == 16'hffff
        |=> st.ctl[cawd_pkg::CTL_OVF] && st.cnt == 16'h0000)
        else $error("overflow flag not set on wrap");
    low_clear_a: assert property (sfr_wr_i
        && sfr_addr_i == cawd_pkg::ADDR_CPL_BASE
        |=> !st.cpm[0][cawd_pkg::CPM_ECOM])
        else $error("low byte write left compare enabled");
    cnt_frozen_a: assert property (wdt_en && !tick && sfr_wr_i
        && sfr_addr_i == cawd_pkg::ADDR_CNT_LO |=> $stable(st.cnt))
        else $error("counter written while watchdog enabled");
    idle_halt_a: assert property (st.md[cawd_pkg::MD_IDLE]
        && cpu_idle_i |-> !tick)
        else $error("counter ticked during suspended idle");
    match_rise_a: assert property (tick && cnt_inc == {st.cph[0], st.cpl[0]}
        && st.cpm[0] == 8'hca |=> module_output_pin_o[0] && st.ctl[0])
        else $error("pwm match did not raise output and flag");
endmodule // cawd_core

// ### verif/cawd_cpu_model.sv
/*
 * Core model: issues accesses on the special function register port.
 * Assumes the bench clock; a strobe rises 5 ns after an edge and
 * falls 5 ns after the edge that takes it.
 */
module cawd_cpu_model (
    // clock
    input  wire logic       ref_clk_i,
    // register port
    output logic      [7:0] sfr_addr_o,
    output logic      [7:0] sfr_wdata_o,
    output logic            sfr_wr_o,
    output logic            sfr_rd_o,
    output logic            sfr_bit_wr_o,
    output logic      [2:0] sfr_bit_idx_o,
    output logic            sfr_bit_val_o,
    input  wire logic [7:0] sfr_rdata_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus idle from time zero
    initial begin
        sfr_addr_o    = 8'h00;
        sfr_wdata_o   = 8'h00;
        sfr_wr_o      = 1'b0;
        sfr_rd_o      = 1'b0;
        sfr_bit_wr_o  = 1'b0;
        sfr_bit_idx_o = 3'h0;
        sfr_bit_val_o = 1'b0;
    end
    // byte write, one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #5;
        sfr_addr_o  = a;
        sfr_wdata_o = d;
        sfr_wr_o    = 1'b1;
        @(posedge ref_clk_i);
        #5;
        sfr_wr_o = 1'b0;
    endtask
    // read; registered data is settled 5 ns after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #5;
        sfr_addr_o = a;
        sfr_rd_o   = 1'b1;
        @(posedge ref_clk_i);
        #5;
        sfr_rd_o = 1'b0;
        d        = sfr_rdata_i;
    endtask
    // single bit write to the control register
    task automatic bwr(input logic [2:0] i, input logic v);
        @(posedge ref_clk_i);
        #5;
        sfr_bit_idx_o = i;
        sfr_bit_val_o = v;
        sfr_bit_wr_o  = 1'b1;
        @(posedge ref_clk_i);
        #5;
        sfr_bit_wr_o = 1'b0;
    endtask
    // low byte first, else compare_enable would end cleared
    task automatic wr_cmp(input logic [2:0] n, input logic [15:0] v);
        wr(cawd_pkg::ADDR_CPL_BASE + {5'h00, n}, v[7:0]);
        wr(cawd_pkg::ADDR_CPH_BASE + {5'h00, n}, v[15:8]);
    endtask
    // watchdog set-up in the only safe order
    task automatic wd_cfg(input logic [2:0] tb, input logic [7:0] off);
        wr(cawd_pkg::ADDR_MODE, 8'h00);
        wr(cawd_pkg::ADDR_MODE, {4'h0, tb, 1'b0});
        wr(cawd_pkg::ADDR_CPL_BASE + 8'h05, off);
        wr(cawd_pkg::ADDR_MODE, {4'h4, tb, 1'b0});
        wr(cawd_pkg::ADDR_CPH_BASE + 8'h05, 8'h00);
    endtask
endmodule // cawd_cpu_model

// ### verif/counter_array_watchdog_pwm16_test.sv
/*
 * Self-checking bench for the counter array core.
 * Assumes cawd_pkg and cawd_core; the core model drives the register
 * port, the external timebase inputs are tied low.
 */
module counter_array_watchdog_pwm16_test;
    timeunit 1ns;
    timeprecision 100ps;
    // clock, reset and nets
    logic       ref_clk_i = 1'b0;
    logic       rst_b_i   = 1'b0;
    logic       cpu_idle  = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr_s;
    logic       rd_s;
    logic       bwr_s;
    logic [2:0] bidx;
    logic       bval;
    logic [5:0] pin;
    logic       wdt;
    int         n_fail    = 0;
    int         cmp_count = 0;
    int         cyc       = 0;
    int         hi0       = 0;
    int         hi1       = 0;
    int         h0;
    int         h1;
    int         t0;
    int         t1;
    int         at;
    int         n;
    logic [7:0] d;

    always #25 ref_clk_i = ~ref_clk_i;

    cawd_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .sfr_addr_o(addr),
        .sfr_wdata_o(wdata), .sfr_wr_o(wr_s), .sfr_rd_o(rd_s),
        .sfr_bit_wr_o(bwr_s), .sfr_bit_idx_o(bidx),
        .sfr_bit_val_o(bval), .sfr_rdata_i(rdata));

    cawd_core dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr_s),
        .sfr_rd_i(rd_s), .sfr_bit_wr_i(bwr_s), .sfr_bit_idx_i(bidx),
        .sfr_bit_val_i(bval), .sfr_rdata_o(rdata), .timer0_ovf_i(1'b0),
        .ext_count_i(1'b0), .ext_clk_i(1'b0), .cpu_idle_i(cpu_idle),
        .module_output_pin_o(pin), .wdt_reset_o(wdt));

    // cycle count and cycles pins 0 and 1 each spend high
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        hi0 <= hi0 + int'(pin[0] === 1'b1);
        hi1 <= hi1 + int'(pin[1] === 1'b1);
    end

    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic rng(input string w, input int lo, input int hi,
                       input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        cpu_u.rd(a, d);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
    endtask

    // release lands 5 ns after an edge; three edges before any access
    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        #5;
        rst_b_i = 1'b1;
        t0      = cyc;
        repeat (3) @(posedge ref_clk_i);
    endtask

    // waits for the reset pulse, then checks it lasted one cycle;
    // looks before the first edge, as a forced pulse already stands
    task automatic wait_wd(output int a);
        a = -1;
        for (int i = 0; i < 4000 && a < 0; i++) begin
            if (wdt === 1'b1) begin
                a = cyc;
            end else begin
                @(posedge ref_clk_i);
                #5;
            end
        end
        @(posedge ref_clk_i);
        #5;
        chk("pulse width", 16'h0000, {15'h0000, wdt});
    endtask

    // stopped counter preloaded 512 counts (0xfe00) short of the wrap
    task automatic prime();
        cpu_u.wr(cawd_pkg::ADDR_CTL, 8'h00);
        cpu_u.wr(cawd_pkg::ADDR_CNT_LO, 8'h00);
        cpu_u.wr(cawd_pkg::ADDR_CNT_HI, 8'hfe);
        h0 = hi0;
        h1 = hi1;
        cpu_u.bwr(3'h6, 1'b1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard: the tests need well under 10000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        $display("mismatch run time expected finish seen hang");
        tally_and_finish();
    end

    initial begin
        // default watchdog and its write blocking
        do_reset();
        rdchk(cawd_pkg::ADDR_MODE, 8'h40);
        rdchk(cawd_pkg::ADDR_CTL, 8'h00);
        rdchk(8'ha5, 8'h00);
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'hce);
        rdchk(cawd_pkg::ADDR_MODE, 8'h40);
        cpu_u.wr(cawd_pkg::ADDR_CNT_HI, 8'h77);
        rdchk(cawd_pkg::ADDR_CNT_HI, 8'h00);
        cpu_u.bwr(3'h6, 1'b1);
        rdchk(cawd_pkg::ADDR_CTL, 8'h40);
        cpu_u.bwr(3'h6, 1'b0);
        wait_wd(at);
        rng("default timeout", 3072, 3090, at - t0);
        t1 = cyc;
        cpu_u.bwr(3'h5, 1'b1);
        wait_wd(at);
        rng("forced reset", 1, 2, at - t1);
        $display("test default done");
        // lock keeps the watchdog on
        do_reset();
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'h00);
        rdchk(cawd_pkg::ADDR_MODE, 8'h00);
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'h20);
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'h00);
        rdchk(cawd_pkg::ADDR_MODE, 8'h20);
        t1 = cyc;
        cpu_u.bwr(3'h5, 1'b1);
        wait_wd(at);
        rng("locked force", 1, 2, at - t1);
        $display("test lock done");
        // update loads high byte plus offset; timeout follows it
        do_reset();
        cpu_u.wd_cfg(cawd_pkg::TB_SYS, 8'h02);
        t1 = cyc;
        rdchk(cawd_pkg::ADDR_CPH_BASE + 8'h05, 8'h02);
        wait_wd(at);
        rng("offset timeout", 750, 772, at - t1);
        $display("test update done");
        // timebase codes, then idle suspend
        do_reset();
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'h00);
        for (int i = 0; i < 8; i++) begin
            cpu_u.wr(cawd_pkg::ADDR_MODE, {4'h0, i[2:0], 1'b0});
            rdchk(cawd_pkg::ADDR_MODE, {4'h0, i[2:0], 1'b0});
        end
        cpu_u.wr(cawd_pkg::ADDR_MODE, 8'h88);
        cpu_u.wr(cawd_pkg::ADDR_CNT_LO, 8'h10);
        cpu_idle = 1'b1;
        cpu_u.bwr(3'h6, 1'b1);
        repeat (20) @(posedge ref_clk_i);
        rdchk(cawd_pkg::ADDR_CNT_LO, 8'h10);
        cpu_idle = 1'b0;
        $display("test idle done");
        // pwm16 on module 0, compare-only on module 1
        cpu_u.wr(cawd_pkg::ADDR_CPM_BASE, 8'hca);
        cpu_u.wr(cawd_pkg::ADDR_CPM_BASE + 8'h01, 8'hc8);
        cpu_u.wr_cmp(3'h0, 16'hff00);
        cpu_u.wr_cmp(3'h1, 16'hff00);
        prime();
        n = 0;
        for (int i = 0; i < 700 && pin[0] !== 1'b1; i++) begin
            @(posedge ref_clk_i);
            #5;
        end
        while (pin[0] === 1'b1 && n < 400) begin
            @(posedge ref_clk_i);
            #5;
            n++;
        end
        chk("pwm high", 16'h0100, n[15:0]);
        chk("pin 1 high", 16'h0000, 16'(hi1 - h1));
        cpu_u.rd(cawd_pkg::ADDR_CTL, d);
        chk("flags", 16'h00c1, {8'h00, d & 8'hc1});
        // low byte alone clears compare_enable: no pulse at all
        cpu_u.wr(cawd_pkg::ADDR_CPL_BASE, 8'h00);
        rdchk(cawd_pkg::ADDR_CPM_BASE, 8'h8a);
        prime();
        repeat (600) @(posedge ref_clk_i);
        chk("pwm off", 16'h0000, 16'(hi0 - h0));
        $display("test pwm done");
        tally_and_finish();
    end
endmodule // counter_array_watchdog_pwm16_test
